// ---- src/iep_core.sv ----
// interrupt enable and priority registers with request arbitration
// Summary of operation
// [RULE_01] main enable bit 7 gates every source
// [RULE_02] main enable bit 6 masks serial peripheral
// [RULE_03] main enable bit 5 masks timer 2 flags
// [RULE_04] main enable bit 4 masks first uart
// [RULE_05] main enable bit 1 masks timer 0
// [RULE_06] main enable bit 2 masks external pin 1
// [RULE_07] main enable bit 0 masks external pin 0
// [RULE_08] low priority bits give level lsb
// [RULE_09] high priority bits give msb, page 0x10
// [RULE_10] priority bit 7 reserved, reads one
// [RULE_11] low priority at 0xb8, all pages, bit-addressable
// [RULE_12] high and low bits pair per source
// [RULE_13] extended enable bit 7 masks timer 3
// [RULE_14] extended enable bit 6 masks comparator 1
// [RULE_15] two bits decode to levels zero to three
// [RULE_16] equal levels: lowest vector index first
// [RULE_17] decode every cycle; preempt only strictly higher
// [RULE_18] pending flags request only when enabled
// [RULE_19] request needs gate, mask, flag, higher level
// [RULE_20] bit write changes only the addressed bit
`timescale 1ns/1ps
`include "iep_regs.svh"
module iep_core #(
  parameter int NSRC = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // special function register port
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_bit_op,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // external request pins, asynchronous
  input wire logic ext_request_pin_zero,
  input wire logic ext_request_pin_one,
  // peripheral pending flags
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag,
  input wire logic uart_first_pending,
  input wire logic timer2_low_overflow_flag,
  input wire logic timer2_high_overflow_flag,
  input wire logic serial_periph_pending,
  input wire logic two_wire_pending,
  input wire logic port_match_pending,
  input wire logic window_compare_pending,
  input wire logic conversion_done_pending,
  input wire logic counter_array_pending,
  input wire logic comparator0_pending,
  input wire logic comparator1_pending,
  input wire logic timer3_low_overflow_flag,
  input wire logic timer3_high_overflow_flag,
  // core sequencer handshake
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic irq_req,
  output logic [4:0] irq_vector_idx,
  output iep_pkg::iep_level_t irq_level,
  output logic [2:0] active_level
);
  import iep_pkg::*;

  logic [7:0] irq_enable_main_reg;
  logic [7:0] priority_low_main_reg;
  logic [7:0] priority_high_main_reg;
  logic [7:0] irq_enable_ext_first_reg;
  logic [1:0] pin_sync;
  logic [NSRC-1:0] pending;
  logic [NSRC-1:0] masks;
  logic [NSRC-1:0] active;
  logic [NSRC-1:0] plo;
  logic [NSRC-1:0] phi;
  logic sel_ie;
  logic sel_plo;
  logic sel_phi;
  logic sel_ext;
  logic arb_found;
  logic [4:0] arb_idx;
  iep_level_t arb_lvl;
  logic [2:0] stack_reg [0:3];
  logic [2:0] depth_reg;
  logic preempt;
  iep_state_t state_reg;
  // deepest nesting: one running handler per level
  localparam logic [2:0] STACK_DEPTH = 3'h4;

  // external pins cross into the clock domain first
  iep_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in({ext_request_pin_one, ext_request_pin_zero}),
    .sync_out(pin_sync)
  );

  // address decode, page 0x10 needed only for the high priority register
  assign sel_ie = (sfr_addr == `IEP_ADDR_IE_MAIN);
  assign sel_plo = (sfr_addr == `IEP_ADDR_PRIO_LO); // RULE_11
  assign sel_phi = (sfr_addr == `IEP_ADDR_PRIO_HI) && (sfr_page == `IEP_PAGE_HI); // RULE_09
  assign sel_ext = (sfr_addr == `IEP_ADDR_IE_EXT1);
  assign sfr_hit = sel_ie | sel_plo | sel_phi | sel_ext;

  // bit-merge helper for single-bit writes
  function automatic logic [7:0] iep_merge(input logic [7:0] old_v, input logic bit_op,
                                           input logic [2:0] sel, input logic [7:0] wd);
    logic [7:0] r;
    r = wd;
    if (bit_op) begin
      r = old_v;
      r[sel] = wd[0];
    end
    return r;
  endfunction : iep_merge

  // main enable register, bit-addressable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_main_reg <= `IEP_RST_IE_MAIN;
    end else if (clk_en && sfr_wr && sel_ie) begin
      irq_enable_main_reg <= iep_merge(irq_enable_main_reg, sfr_bit_op, sfr_bit_sel,
                                       sfr_wdata); // RULE_20
    end
  end

  // low priority register, reserved bit held at one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      priority_low_main_reg <= `IEP_RST_PRIO;
    end else if (clk_en && sfr_wr && sel_plo) begin
      priority_low_main_reg <= iep_merge(priority_low_main_reg, sfr_bit_op, sfr_bit_sel,
                                         sfr_wdata) | `IEP_PRIO_RSVD_MASK; // RULE_10 RULE_20
    end
  end

  // high priority register, byte writes only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      priority_high_main_reg <= `IEP_RST_PRIO;
    end else if (clk_en && sfr_wr && sel_phi && !sfr_bit_op) begin
      priority_high_main_reg <= sfr_wdata | `IEP_PRIO_RSVD_MASK; // RULE_10
    end
  end

  // first extended enable register, byte writes only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_ext_first_reg <= `IEP_RST_IE_EXT1;
    end else if (clk_en && sfr_wr && sel_ext && !sfr_bit_op) begin
      irq_enable_ext_first_reg <= sfr_wdata;
    end
  end

  // registered read data, zero on unmapped address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (clk_en && sfr_rd) begin
      if (sel_ie) begin
        sfr_rdata <= irq_enable_main_reg;
      end else if (sel_plo) begin
        sfr_rdata <= priority_low_main_reg;
      end else if (sel_phi) begin
        sfr_rdata <= priority_high_main_reg;
      end else if (sel_ext) begin
        sfr_rdata <= irq_enable_ext_first_reg;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  // pending flags in vector-table order; pins are low-active and the
  // synchroniser clears to their idle high level
  always_comb begin
    pending = '0;
    pending[0] = !pin_sync[0];
    pending[1] = timer0_overflow_flag;
    pending[2] = !pin_sync[1];
    pending[3] = timer1_overflow_flag;
    pending[4] = uart_first_pending;
    pending[5] = timer2_low_overflow_flag | timer2_high_overflow_flag; // RULE_03
    pending[6] = serial_periph_pending;
    pending[7] = two_wire_pending;
    pending[8] = port_match_pending;
    pending[9] = window_compare_pending;
    pending[10] = conversion_done_pending;
    pending[11] = counter_array_pending;
    pending[12] = comparator0_pending;
    pending[13] = comparator1_pending;
    pending[14] = timer3_low_overflow_flag | timer3_high_overflow_flag; // RULE_13
  end

  // per-source masks and priority bits
  always_comb begin
    masks = '0;
    plo = '0;
    phi = '0;
    masks[0] = irq_enable_main_reg[`IEP_BIT_X0]; // RULE_07
    masks[1] = irq_enable_main_reg[`IEP_BIT_T0]; // RULE_05
    masks[2] = irq_enable_main_reg[`IEP_BIT_X1]; // RULE_06
    masks[3] = irq_enable_main_reg[`IEP_BIT_T1];
    masks[4] = irq_enable_main_reg[`IEP_BIT_UART]; // RULE_04
    masks[5] = irq_enable_main_reg[`IEP_BIT_T2]; // RULE_03
    masks[6] = irq_enable_main_reg[`IEP_BIT_SPI]; // RULE_02
    masks[7] = irq_enable_ext_first_reg[`IEP_BIT_SMB];
    masks[8] = irq_enable_ext_first_reg[`IEP_BIT_PMAT];
    masks[9] = irq_enable_ext_first_reg[`IEP_BIT_WADC];
    masks[10] = irq_enable_ext_first_reg[`IEP_BIT_ADC];
    masks[11] = irq_enable_ext_first_reg[`IEP_BIT_PCA];
    masks[12] = irq_enable_ext_first_reg[`IEP_BIT_CP0];
    masks[13] = irq_enable_ext_first_reg[`IEP_BIT_CP1]; // RULE_14
    masks[14] = irq_enable_ext_first_reg[`IEP_BIT_T3]; // RULE_13
    plo[6:0] = priority_low_main_reg[6:0]; // RULE_08
    phi[6:0] = priority_high_main_reg[6:0]; // RULE_09 RULE_12
  end

  // gate, mask and flag must all be set
  assign active = pending & masks & {NSRC{irq_enable_main_reg[`IEP_BIT_GATE]}}; // RULE_01 RULE_18

  iep_arbiter #(
    .NSRC(NSRC)
  ) u_arb (
    .active(active),
    .prio_lo(plo),
    .prio_hi(phi),
    .found(arb_found),
    .win_idx(arb_idx),
    .win_lvl(arb_lvl)
  );

  // strictly higher than the running handler; reads zero when none is running,
  // so a level-zero handler can only be preempted by levels one to three
  assign active_level = (depth_reg == 3'h0) ? `IEP_LVL_NONE : stack_reg[2'(depth_reg - 3'h1)];
  assign preempt = arb_found &&
                   ((depth_reg == 3'h0) || ({1'b0, arb_lvl} > active_level)); // RULE_17 RULE_19

  // request output, re-decoded every enabled cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
      irq_vector_idx <= 5'h00;
      irq_level <= 2'h0;
      state_reg <= IEP_ST_IDLE;
    end else if (clk_en) begin
      irq_req <= preempt && !irq_ack; // RULE_17 RULE_19
      irq_vector_idx <= arb_idx;
      irq_level <= arb_lvl;
      case (state_reg)
        IEP_ST_IDLE: begin
          if (preempt) begin
            state_reg <= IEP_ST_REQ;
          end
        end
        IEP_ST_REQ: begin
          if (irq_ack) begin
            state_reg <= IEP_ST_SERVE;
          end else if (!preempt) begin
            state_reg <= IEP_ST_IDLE;
          end
        end
        IEP_ST_SERVE: begin
          if (irq_return && depth_reg == 3'h1) begin
            state_reg <= IEP_ST_IDLE;
          end else if (preempt) begin
            state_reg <= IEP_ST_REQ;
          end
        end
        default: begin
          state_reg <= IEP_ST_IDLE;
        end
      endcase
    end
  end

  // nesting stack of in-service levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      depth_reg <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        stack_reg[i] <= 3'h0;
      end
    end else if (clk_en) begin
      if (irq_ack && irq_req && depth_reg < STACK_DEPTH) begin
        stack_reg[depth_reg[1:0]] <= {1'b0, irq_level};
        depth_reg <= depth_reg + 3'h1;
      end else if (irq_return && depth_reg != 3'h0) begin
        depth_reg <= depth_reg - 3'h1;
      end
    end
  end
endmodule : iep_core

// ---- src/iep_regs.svh ----
// register offsets, field positions and reset values of the interrupt enable and priority block
`ifndef IEP_REGS_SVH
`define IEP_REGS_SVH
`define IEP_ADDR_IE_MAIN 8'ha8
`define IEP_ADDR_PRIO_LO 8'hb8
`define IEP_ADDR_IE_EXT1 8'he6
`define IEP_ADDR_PRIO_HI 8'hf2
`define IEP_PAGE_HI 8'h10
`define IEP_RST_IE_MAIN 8'h00
`define IEP_RST_PRIO 8'h80
`define IEP_RST_IE_EXT1 8'h00
`define IEP_PRIO_RSVD_MASK 8'h80
`define IEP_BIT_GATE 7
`define IEP_BIT_SPI 6
`define IEP_BIT_T2 5
`define IEP_BIT_UART 4
`define IEP_BIT_T1 3
`define IEP_BIT_X1 2
`define IEP_BIT_T0 1
`define IEP_BIT_X0 0
`define IEP_BIT_T3 7
`define IEP_BIT_CP1 6
`define IEP_BIT_CP0 5
`define IEP_BIT_PCA 4
`define IEP_BIT_ADC 3
`define IEP_BIT_WADC 2
`define IEP_BIT_PMAT 1
`define IEP_BIT_SMB 0
`define IEP_LVL_NONE 3'h0
`endif

// ---- src/iep_pkg.sv ----
// types shared by the interrupt enable and priority block
package iep_pkg;
  typedef logic [1:0] iep_level_t;
  typedef enum logic [1:0] {
    IEP_ST_IDLE = 2'b00,
    IEP_ST_REQ = 2'b01,
    IEP_ST_SERVE = 2'b10
  } iep_state_t;
endpackage : iep_pkg

// ---- src/iep_sync.sv ----
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module iep_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;

  // first stage feeds only the second; both clear to ones, the idle level of the
  // low-active pins, so no false request shows while the pins settle after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= '1;
      sync_out <= '1;
    end else if (clk_en) begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule : iep_sync

// ---- src/iep_arbiter.sv ----
// picks the highest level pending source, lowest index wins ties
`timescale 1ns/1ps
module iep_arbiter #(
  parameter int NSRC = 16
) (
  // candidate sources
  input wire logic [NSRC-1:0] active,
  input wire logic [NSRC-1:0] prio_lo,
  input wire logic [NSRC-1:0] prio_hi,
  // winner
  output logic found,
  output logic [4:0] win_idx,
  output iep_pkg::iep_level_t win_lvl
);
  import iep_pkg::*;

  // scan downward so the lowest index at the top level is kept last
  always_comb begin
    found = 1'b0;
    win_idx = 5'h00;
    win_lvl = 2'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (active[i] && (!found || {prio_hi[i], prio_lo[i]} >= win_lvl)) begin // RULE_15 RULE_16
        found = 1'b1;
        win_idx = 5'(i);
        win_lvl = {prio_hi[i], prio_lo[i]}; // RULE_08 RULE_09 RULE_12
      end
    end
  end
endmodule : iep_arbiter

// ---- testbench/iep_core_assertions.sv ----
// port-level checks for the interrupt enable and priority block
`timescale 1ns/1ps
module iep_core_assertions
  import iep_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  // core handshake
  input wire logic irq_ack,
  input wire logic irq_req,
  input wire logic [4:0] irq_vector_idx,
  input wire iep_pkg::iep_level_t irq_level,
  input wire logic [2:0] active_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // the core takes the standing request on an enabled edge
  sequence s_take;
    clk_en && irq_req && irq_ack;
  endsequence
  // an enabled priority register read, then the edge at which the answer stands
  sequence s_prio_read;
    clk_en && sfr_rd && sfr_hit && (sfr_addr == 8'hb8 || sfr_addr == 8'hf2) ##1 1'b1;
  endsequence
  ack_drop_a: assert property (s_take |=> !irq_req)
    else $error("request still up after acknowledge");
  take_level_a: assert property ((s_take ##0 irq_level != 2'h0) |=>
    active_level == {1'b0, $past(irq_level)}) else $error("running level not taken over");
  vec_range_a: assert property (irq_req |-> irq_vector_idx <= 5'd14)
    else $error("winner index outside source range");
  fixed_level_a: assert property (irq_req && irq_vector_idx > 5'd6 |-> irq_level == 2'h0)
    else $error("extended source not at level zero");
  preempt_a: assert property (irq_req && active_level != 3'h0 |->
    {1'b0, irq_level} > active_level) else $error("request not above running level");
  unmapped_rd_a: assert property (clk_en && sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  rsvd_one_a: assert property (s_prio_read |-> sfr_rdata[7])
    else $error("reserved priority bit reads zero");
  hit_map_a: assert property (sfr_addr == 8'ha8 || sfr_addr == 8'hb8 |-> sfr_hit)
    else $error("enable or low priority address not decoded");
  // clock enable low holds the request, its level, the read data and the running level
  freeze_a: assert property (!clk_en |=> $stable(irq_req) && $stable(irq_level) &&
    $stable(sfr_rdata) && $stable(active_level))
    else $error("state moved while clock enable low");
endmodule : iep_core_assertions

bind iep_core iep_core_assertions iep_core_assertions_inst (.*);

// ---- testbench/iep_cpu_model.sv ----
// core sequencer stand-in: takes requests after a delay, ends handlers on command
`timescale 1ns/1ps
module iep_cpu_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // controls from the bench
  input wire logic ack_en,
  input wire logic ret_cmd,
  // request handshake
  input wire logic irq_req,
  output logic irq_ack,
  output logic irq_return
);
  logic [3:0] wait_reg;
  // acknowledge after seven request cycles, one-cycle pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 4'h0;
      irq_ack <= 1'b0;
    end else begin
      irq_ack <= irq_req && ack_en && !irq_ack && wait_reg == 4'h6;
      wait_reg <= (irq_req && ack_en && !irq_ack && wait_reg != 4'h6) ? wait_reg + 4'h1 : 4'h0;
    end
  end
  // handler end follows the bench command by one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) irq_return <= 1'b0;
    else irq_return <= ret_cmd;
  end
endmodule : iep_cpu_model

// ---- testbench/test_iep_core.sv ----
// self-checking bench for the interrupt enable and priority block
`timescale 1ns/1ps
module test_iep_core;
  import iep_pkg::*;
  logic clk = 0, rst_n = 0, clk_en = 1, sfr_wr = 0, sfr_rd = 0, sfr_bit_op = 0, sfr_hit;
  logic [7:0] sfr_page = 0, sfr_addr = 0, sfr_wdata = 0, sfr_rdata;
  logic [2:0] sfr_bit_sel = 0, active_level;
  logic [16:0] src = 0;
  logic ack_en = 0, ret_cmd = 0, irq_ack, irq_return, irq_req;
  logic [4:0] irq_vector_idx;
  iep_level_t irq_level;
  int mismatches = 0, check_count = 0, cycles = 0;
  // 125 MHz clock
  always #4 clk = ~clk;
  // pins are active low; src holds one bit per flag input, two each for sources 5 and 14
  iep_core iep_core_inst (.*, .ext_request_pin_zero(~src[0]), .timer0_overflow_flag(src[1]),
    .ext_request_pin_one(~src[2]), .timer1_overflow_flag(src[3]), .uart_first_pending(src[4]),
    .timer2_low_overflow_flag(src[5]), .serial_periph_pending(src[6]),
    .two_wire_pending(src[7]), .port_match_pending(src[8]), .window_compare_pending(src[9]),
    .conversion_done_pending(src[10]), .counter_array_pending(src[11]),
    .comparator0_pending(src[12]), .comparator1_pending(src[13]),
    .timer3_low_overflow_flag(src[14]), .timer2_high_overflow_flag(src[15]),
    .timer3_high_overflow_flag(src[16]));
  iep_cpu_model iep_cpu_model_inst (.*);
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, d, pg = 0, input logic bop = 0, input logic [2:0] sel = 0);
    @(negedge clk);
    {sfr_addr, sfr_wdata, sfr_page, sfr_bit_op, sfr_bit_sel, sfr_wr} = {a, d, pg, bop, sel, 1'b1};
    @(negedge clk);
    sfr_wr = 0;
  endtask : wr
  task rd(input logic [7:0] a, e, pg = 0);
    @(negedge clk);
    {sfr_addr, sfr_page, sfr_rd} = {a, pg, 1'b1};
    @(negedge clk);
    sfr_rd = 0;
    @(negedge clk);
    chk("sfr_rdata", e, sfr_rdata);
  endtask : rd
  task req(input logic r, input logic [4:0] i, input logic [1:0] l);
    repeat (4) @(negedge clk);
    chk("irq_req", r, irq_req);
    if (r) begin
      chk("irq_vector_idx", i, irq_vector_idx);
      chk("irq_level", l, irq_level);
    end
  endtask : req
  task t_reset;
    rd(8'ha8, 8'h00);
    rd(8'hb8, 8'h80, 8'h05);
    rd(8'he6, 8'h00);
    rd(8'hf2, 8'h80, 8'h10);
    rd(8'h11, 8'h00);
  endtask : t_reset
  task t_masks;
    int v;
    for (int i = 0; i < 17; i++) begin
      v = (i == 15) ? 5 : (i == 16) ? 14 : i;
      wr(8'ha8, 8'h80 | (v < 7 ? 8'h01 << v : 8'h00));
      wr(8'he6, v < 7 ? 8'h00 : 8'h01 << (v - 7));
      src = 17'h1 << i;
      req(1, 5'(v), 0);
      wr(8'ha8, v < 7 ? 8'h01 << v : 8'h00);
      req(0, 0, 0);
      wr(8'ha8, 8'h80);
      wr(8'he6, 8'h00);
      req(0, 0, 0);
      src = 0;
    end
  endtask : t_masks
  task t_prio;
    wr(8'ha8, 8'hc2);
    src = 17'h42;
    for (int l = 0; l < 4; l++) begin
      wr(8'hb8, {1'b1, l[0], 6'h02 & 6'h00});
      wr(8'hf2, {1'b1, l[1], 6'h00}, 8'h10);
      req(1, l == 0 ? 5'd1 : 5'd6, 2'(l));
    end
    wr(8'hf2, 8'h80, 8'h00);
    rd(8'hf2, 8'hc0, 8'h10);
    src = 0;
  endtask : t_prio
  task t_bits;
    wr(8'ha8, 8'h81);
    wr(8'ha8, 8'h01, 8'h00, 1, 3);
    rd(8'ha8, 8'h89);
    wr(8'hb8, 8'h00, 8'h00, 1, 7);
    rd(8'hb8, 8'hc0);
    wr(8'hb8, 8'h00, 8'h00, 1, 6);
    rd(8'hb8, 8'h80);
    wr(8'he6, 8'h01, 8'h00, 1, 2);
    rd(8'he6, 8'h00);
  endtask : t_bits
  task t_preempt;
    wr(8'ha8, 8'hc2);
    wr(8'hb8, 8'hc2);
    wr(8'hf2, 8'h80, 8'h10);
    ack_en = 1;
    src = 17'h2;
    req(1, 1, 1);
    repeat (10) @(negedge clk);
    chk("active_level", 1, active_level);
    src = 17'h42;
    req(0, 0, 0);
    wr(8'hf2, 8'hc0, 8'h10);
    req(1, 6, 3);
    repeat (10) @(negedge clk);
    chk("active_level", 3, active_level);
    ack_en = 0;
    src = 0;
    repeat (2) begin
      @(negedge clk);
      ret_cmd = 1;
      @(negedge clk);
      ret_cmd = 0;
    end
    @(negedge clk);
    chk("active_level", 0, active_level);
  endtask : t_preempt
  // clock enable low drops writes and holds the request
  task t_freeze;
    wr(8'ha8, 8'h82);
    clk_en = 0;
    src = 17'h2;
    wr(8'ha8, 8'h00);
    req(0, 0, 0);
    clk_en = 1;
    req(1, 1, 1);
    rd(8'ha8, 8'h82);
    src = 0;
  endtask : t_freeze
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      complete_run;
    end
  end
  // main sequence
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    t_reset;
    t_masks;
    t_prio;
    t_bits;
    t_preempt;
    t_freeze;
    // a second reset in mid-run must restore every register
    rst_n = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    t_reset;
    complete_run;
  end
endmodule : test_iep_core
